// >>> kds_pkg.sv
// Shared constants, state layout and helper functions for the key and switch scanner
package kds_pkg;

  // Timing of one scan step
  localparam int KDS_CLK_HZ       = 10_000_000;
  localparam int KDS_SCAN_TIME_US = 1000;
  localparam int KDS_SCAN_CYCLES  = (KDS_CLK_HZ / 1_000_000) * KDS_SCAN_TIME_US;
  localparam int KDS_DIV_W        = 24;

  // Pin vector layout after synchronisation
  localparam int KDS_TK_KEYS = 10;
  localparam int KDS_PIN_TK  = 0;
  localparam int KDS_PIN_MX  = 10;
  localparam int KDS_PIN_TW  = 14;
  localparam int KDS_PINS    = 22;

  // Field positions and limits
  localparam int         KDS_TK_ANY_BIT = 10;
  localparam logic [3:0] KDS_KEY_A      = 4'ha;
  localparam logic [3:0] KDS_LAST_STEP  = 4'h3;
  localparam logic [15:0] KDS_TK_MAX    = 16'h270f;
  localparam logic [1:0] KDS_TW_ONE     = 2'h1;
  localparam logic [1:0] KDS_TW_TWO     = 2'h2;

  typedef struct packed {
    logic [KDS_PINS-1:0]  s1;
    logic [KDS_PINS-1:0]  s2;
    logic [KDS_PINS-1:0]  s3;
    logic [KDS_PINS-1:0]  filt;
    logic [KDS_DIV_W-1:0] div_cnt;
    logic                 tick;
    logic [9:0]           tk_prev;
    logic [15:0]          tk_dig;
    logic [15:0]          tk_bin;
    logic [9:0]           tk_ind;
    logic                 tk_any;
    logic [1:0]           mx_col;
    logic [15:0]          mx_map;
    logic [15:0]          mx_prev;
    logic [31:0]          mx_dig;
    logic [31:0]          mx_bin;
    logic [5:0]           mx_fn;
    logic                 mx_letter;
    logic                 mx_digit;
    logic                 mx_done;
    logic [3:0]           mx_drive;
    logic [1:0]           tw_step;
    logic [15:0]          tw_dig0;
    logic [15:0]          tw_dig1;
    logic [15:0]          tw_word0;
    logic [15:0]          tw_word1;
    logic                 tw_done;
    logic [3:0]           tw_strobe;
  } kds_state_type;

  localparam kds_state_type KDS_STATE_RST = '0;

  // Eight packed BCD digits to binary, most significant nibble first
  function automatic logic [31:0] kds_bcd2bin(input logic [31:0] bcd);
    logic [31:0] acc;
    acc = '0;
    for (int i = 7; i >= 0; i--) begin
      acc = 32'(acc * 32'd10 + 32'(bcd[i*4 +: 4]));
    end
    return acc;
  endfunction

  // Lowest set bit as {valid, index}
  function automatic logic [4:0] kds_first_key(input logic [15:0] m);
    logic [4:0] r;
    r = '0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

// >>> kds_scanner.sv
// Ten-key entry, matrix keypad scanner and thumbwheel reader in one clocked block
`timescale 1ns/1ns
module kds_scanner
  import kds_pkg::*;
#(
  parameter int SCAN_CYCLES = KDS_SCAN_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [9:0]  ten_key_keys,
  input  wire logic        ten_key_enable,
  output logic [15:0]      ten_key_result,
  output logic [10:0]      ten_key_status,
  input  wire logic [3:0]  keypad_return,
  output logic [3:0]       keypad_drive,
  input  wire logic        matrix_enable,
  input  wire logic        hex_mode_flag,
  input  wire logic        matrix_keypad_entry_wide,
  output logic [31:0]      keypad_result,
  output logic [7:0]       keypad_status,
  output logic             keypad_done_flag,
  input  wire logic [7:0]  thumbwheel_in,
  input  wire logic [1:0]  thumbwheel_count,
  input  wire logic        thumbwheel_enable,
  output logic [3:0]       thumbwheel_strobe,
  output logic [15:0]      thumbwheel_word0,
  output logic [15:0]      thumbwheel_word1,
  output logic             thumbwheel_done_flag
);

  // The divider counter must hold the step length
  if (SCAN_CYCLES < 1 || SCAN_CYCLES >= (1 << KDS_DIV_W)) begin : g_bad_scan
    $error("SCAN_CYCLES out of range");
  end

  kds_state_type st_q;
  kds_state_type st_d;
  logic [KDS_PINS-1:0] pins;
  logic [4:0]          pick_tk;
  logic [4:0]          pick_mx;
  logic [15:0]         map;
  logic [31:0]         mdig;
  logic [15:0]         tdig0;
  logic [15:0]         tdig1;
  logic                tw_active;

  // All pins arrive from outside the clock domain
  assign pins = {thumbwheel_in, keypad_return, ten_key_keys};

  // Next state of the whole block
  always_comb begin
    pick_tk   = '0;
    pick_mx   = '0;
    map       = '0;
    mdig      = '0;
    tdig0     = '0;
    tdig1     = '0;
    tw_active = thumbwheel_enable &&
                (thumbwheel_count == KDS_TW_ONE || thumbwheel_count == KDS_TW_TWO);
    st_d      = st_q;

    // Three-stage synchroniser; a change counts once stages two and three agree
    st_d.s1   = pins;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.filt = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.filt & (st_q.s2 ^ st_q.s3));

    // Scan step enable pulse
    if (st_q.div_cnt == KDS_DIV_W'(SCAN_CYCLES - 1)) begin
      st_d.div_cnt = '0;
      st_d.tick    = 1'b1;
    end else begin
      st_d.div_cnt = KDS_DIV_W'(st_q.div_cnt + 1'b1);
      st_d.tick    = 1'b0;
    end

    // Ten-key entry: only a fresh press counts, lowest key first
    st_d.tk_prev = st_q.filt[KDS_PIN_TK +: KDS_TK_KEYS];
    pick_tk = kds_first_key({6'h0, st_q.filt[KDS_PIN_TK +: KDS_TK_KEYS] & ~st_q.tk_prev});
    if (!ten_key_enable) begin
      st_d.tk_ind = '0;
      st_d.tk_any = 1'b0;
    end else begin
      st_d.tk_any = |st_q.filt[KDS_PIN_TK +: KDS_TK_KEYS];
      if (pick_tk[4]) begin
        // Oldest digit falls off the top, so the value never passes four digits
        st_d.tk_dig = {st_q.tk_dig[11:0], pick_tk[3:0]};
        st_d.tk_bin = 16'(kds_bcd2bin({16'h0, st_d.tk_dig}));
        st_d.tk_ind = 10'h001 << pick_tk[3:0];
      end
    end

    // Matrix keypad: returns sampled at the end of each drive step
    if (!matrix_enable) begin
      st_d.mx_col    = '0;
      st_d.mx_map    = '0;
      st_d.mx_prev   = '0;
      st_d.mx_drive  = '0;
      st_d.mx_fn     = '0;
      st_d.mx_letter = 1'b0;
      st_d.mx_digit  = 1'b0;
      st_d.mx_done   = 1'b0;
    end else if (st_q.tick) begin
      map = st_q.mx_map;
      map[{st_q.mx_col, 2'b00} +: 4] = st_q.filt[KDS_PIN_MX +: 4];
      st_d.mx_done = 1'b0;
      if ({2'b00, st_q.mx_col} == KDS_LAST_STEP) begin
        pick_mx = kds_first_key(map & ~st_q.mx_prev);
        st_d.mx_letter = |map[15:10];
        st_d.mx_digit  = |map[9:0];
        if (pick_mx[4]) begin
          if (hex_mode_flag || pick_mx[3:0] < KDS_KEY_A) begin
            mdig = {st_q.mx_dig[27:0], pick_mx[3:0]};
            if (!matrix_keypad_entry_wide) begin
              mdig[31:16] = '0;
            end
            st_d.mx_dig = mdig;
            st_d.mx_bin = hex_mode_flag ? mdig : kds_bcd2bin(mdig);
          end else if (st_q.mx_prev[15:10] == 6'h00) begin
            // A function key still held from an earlier pass blocks newcomers
            st_d.mx_fn = 6'h01 << (pick_mx[3:0] - KDS_KEY_A);
          end
        end
        st_d.mx_prev = map;
        map          = '0;
        st_d.mx_done = 1'b1;
      end
      st_d.mx_map   = map;
      st_d.mx_col   = 2'(st_q.mx_col + 1'b1);
      st_d.mx_drive = 4'h1 << st_d.mx_col;
    end else if (st_q.mx_drive == 4'h0) begin
      st_d.mx_drive = 4'h1 << st_q.mx_col;
    end

    // Thumbwheel reader: step i reads the digit of weight ten to the i
    if (!tw_active) begin
      st_d.tw_step   = '0;
      st_d.tw_strobe = '0;
      st_d.tw_done   = 1'b0;
    end else if (st_q.tick) begin
      tdig0 = st_q.tw_dig0;
      tdig1 = st_q.tw_dig1;
      tdig0[{st_q.tw_step, 2'b00} +: 4] = st_q.filt[KDS_PIN_TW +: 4];
      tdig1[{st_q.tw_step, 2'b00} +: 4] = st_q.filt[KDS_PIN_TW + 4 +: 4];
      st_d.tw_dig0 = tdig0;
      st_d.tw_dig1 = tdig1;
      st_d.tw_done = 1'b0;
      if ({2'b00, st_q.tw_step} == KDS_LAST_STEP) begin
        st_d.tw_word0 = 16'(kds_bcd2bin({16'h0, tdig0}));
        if (thumbwheel_count == KDS_TW_TWO) begin
          st_d.tw_word1 = 16'(kds_bcd2bin({16'h0, tdig1}));
        end
        st_d.tw_done = 1'b1;
      end
      st_d.tw_step   = 2'(st_q.tw_step + 1'b1);
      st_d.tw_strobe = 4'h1 << st_d.tw_step;
    end else if (st_q.tw_strobe == 4'h0) begin
      st_d.tw_strobe = 4'h1 << st_q.tw_step;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= KDS_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign ten_key_result       = st_q.tk_bin;
  assign ten_key_status       = {st_q.tk_any, st_q.tk_ind};
  assign keypad_drive         = st_q.mx_drive;
  assign keypad_result        = st_q.mx_bin;
  assign keypad_status        = {st_q.mx_digit, st_q.mx_letter, st_q.mx_fn};
  assign keypad_done_flag     = st_q.mx_done;
  assign thumbwheel_strobe    = st_q.tw_strobe;
  assign thumbwheel_word0     = st_q.tw_word0;
  assign thumbwheel_word1     = st_q.tw_word1;
  assign thumbwheel_done_flag = st_q.tw_done;

  // Checks on the driven outputs
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  tk_off_clear_a: assert property (!ten_key_enable |=> ten_key_status == 11'h000)
    else $error("ten-key status not cleared when disabled");
  tk_off_hold_a: assert property (!ten_key_enable |=> $stable(ten_key_result))
    else $error("ten-key result changed while disabled");
  tk_onehot_a: assert property ($onehot0(ten_key_status[9:0]))
    else $error("more than one ten-key indicator set");
  tk_limit_a: assert property (ten_key_result <= KDS_TK_MAX)
    else $error("ten-key result above four digits");
  tk_any_a: assert property (ten_key_enable && |st_q.filt[9:0] |=> ten_key_status[KDS_TK_ANY_BIT])
    else $error("any-key bit missing");
  mx_done_a: assert property (keypad_done_flag && st_q.tick |=> !keypad_done_flag)
    else $error("keypad done longer than one scan step");
  mx_drive_a: assert property ($onehot0(keypad_drive))
    else $error("more than one keypad drive active");
  mx_fn_a: assert property ($onehot0(keypad_status[5:0]))
    else $error("more than one function bit latched");
  mx_off_a: assert property (!matrix_enable |=> keypad_status == 8'h00 && $stable(keypad_result))
    else $error("keypad status not cleared when disabled");
  mx_narrow_a: assert property (matrix_enable && !matrix_keypad_entry_wide && st_q.tick
                                |=> keypad_result[31:16] == 16'h0000 || $stable(keypad_result))
    else $error("narrow keypad result too wide");
  tw_off_a: assert property (!thumbwheel_enable |=> thumbwheel_strobe == 4'h0)
    else $error("thumbwheel strobe active while disabled");
  tw_done_a: assert property ($rose(thumbwheel_done_flag) |-> $past(st_q.tw_step) == 2'h3)
    else $error("thumbwheel done not at end of pass");

  // With entry enabled, the ten-key indicator must not drift while no fresh press arrives
  property p_tk_hold;
    ten_key_enable && !pick_tk[4] |=> $stable(ten_key_status[9:0]);
  endproperty
  tk_hold_a: assert property (p_tk_hold)
    else $error("ten-key indicator moved without a press");

  // A taken press always leaves exactly one indicator lit
  property p_tk_set;
    ten_key_enable && pick_tk[4] |=> $onehot(ten_key_status[9:0]);
  endproperty
  tk_set_a: assert property (p_tk_set)
    else $error("ten-key press left no indicator");

  // Any-key bit follows the filtered keys, so it drops once all are released
  property p_tk_idle;
    ten_key_enable && ~|st_q.filt[9:0] |=> !ten_key_status[KDS_TK_ANY_BIT];
  endproperty
  tk_idle_a: assert property (p_tk_idle)
    else $error("any-key bit set with no key held");

  // Result only moves on a fresh press
  property p_tk_keep;
    !pick_tk[4] |=> $stable(ten_key_result);
  endproperty
  tk_keep_a: assert property (p_tk_keep)
    else $error("ten-key result changed without a press");

  // The any-key bit can only stem from an enabled cycle
  property p_tk_gate;
    ten_key_status[KDS_TK_ANY_BIT] |-> $past(ten_key_enable);
  endproperty
  tk_gate_a: assert property (p_tk_gate)
    else $error("any-key bit set after disable");

  // While enabled exactly one drive column is active
  property p_mx_on;
    matrix_enable |=> $onehot(keypad_drive);
  endproperty
  mx_on_a: assert property (p_mx_on)
    else $error("keypad drive not one-hot while enabled");

  // A drive column stands for the whole step; returns need it to settle
  property p_mx_step;
    matrix_enable && !st_q.tick && keypad_drive != 4'h0 |=> $stable(keypad_drive);
  endproperty
  mx_step_a: assert property (p_mx_step)
    else $error("keypad drive moved inside a step");

  // While enabled, result and status only change on a scan step
  property p_mx_quiet;
    matrix_enable && !st_q.tick |=> $stable(keypad_result) && $stable(keypad_status);
  endproperty
  mx_quiet_a: assert property (p_mx_quiet)
    else $error("keypad outputs changed between steps");

  // Done rises only at the step that samples the last column
  property p_mx_done_end;
    $rose(keypad_done_flag) |-> $past(st_q.tick) && $past(st_q.mx_col) == 2'h3;
  endproperty
  mx_done_end_a: assert property (p_mx_done_end)
    else $error("keypad done not at end of pass");

  // While enabled, done stands until the next step, never shorter
  property p_mx_done_hold;
    keypad_done_flag && matrix_enable && !st_q.tick |=> keypad_done_flag;
  endproperty
  mx_done_hold_a: assert property (p_mx_done_hold)
    else $error("keypad done shorter than one scan step");

  // In hex mode letter keys are digits, so function bits are left alone
  property p_mx_hex_fn;
    matrix_enable && hex_mode_flag |=> $stable(keypad_status[5:0]);
  endproperty
  mx_hex_fn_a: assert property (p_mx_hex_fn)
    else $error("function bit changed in hex mode");

  // Function bits latch; while enabled only the end of a pass may move them
  property p_mx_fn_keep;
    matrix_enable && !(st_q.tick && st_q.mx_col == 2'h3) |=> $stable(keypad_status[5:0]);
  endproperty
  mx_fn_keep_a: assert property (p_mx_fn_keep)
    else $error("function bit changed inside a pass");

  // An active reader drives exactly one strobe
  property p_tw_on;
    tw_active |=> $onehot(thumbwheel_strobe);
  endproperty
  tw_on_a: assert property (p_tw_on)
    else $error("thumbwheel strobe not one-hot while active");

  // A switch count other than one or two leaves the reader idle
  property p_tw_idle;
    thumbwheel_count != KDS_TW_ONE && thumbwheel_count != KDS_TW_TWO |=> thumbwheel_strobe == 4'h0;
  endproperty
  tw_idle_a: assert property (p_tw_idle)
    else $error("thumbwheel strobe active with bad count");

  // With one switch the second word keeps its last value
  property p_tw_one;
    thumbwheel_count != KDS_TW_TWO |=> $stable(thumbwheel_word1);
  endproperty
  tw_one_a: assert property (p_tw_one)
    else $error("second thumbwheel word changed with one switch");

  // Words only change on a scan step
  property p_tw_quiet;
    !st_q.tick |=> $stable(thumbwheel_word0) && $stable(thumbwheel_word1);
  endproperty
  tw_quiet_a: assert property (p_tw_quiet)
    else $error("thumbwheel word changed between steps");

  // Done lasts one step only
  property p_tw_done_once;
    thumbwheel_done_flag && st_q.tick |=> !thumbwheel_done_flag;
  endproperty
  tw_done_once_a: assert property (p_tw_done_once)
    else $error("thumbwheel done longer than one scan step");

  // A strobe stands for the whole step so the digit can settle
  property p_tw_step;
    tw_active && !st_q.tick && thumbwheel_strobe != 4'h0 |=> $stable(thumbwheel_strobe);
  endproperty
  tw_step_a: assert property (p_tw_step)
    else $error("thumbwheel strobe moved inside a step");

  hex_entry_c: cover property (hex_mode_flag && $changed(keypad_result));
  fn_key_c: cover property (!hex_mode_flag && $changed(keypad_status[5:0]) && |keypad_status[5:0]);
  tw_two_c: cover property (thumbwheel_count == KDS_TW_TWO && $rose(thumbwheel_done_flag));
  tk_entry_c: cover property (ten_key_enable && $changed(ten_key_result));

endmodule

// >>> kds_keys_model.sv
// Behavioural keypad matrix and thumbwheel switches as seen from the scanner pins
`timescale 1ns/1ns
module kds_keys_model
  import kds_pkg::*;
(
  input  wire logic [3:0]  keypad_drive,
  input  wire logic [15:0] key_map,
  input  wire logic [3:0]  thumbwheel_strobe,
  input  wire logic [15:0] sw0,
  input  wire logic [15:0] sw1,
  output logic [3:0]       keypad_return,
  output logic [7:0]       thumbwheel_in
);
  // A closed key joins its drive column to one return; undriven lines sit on their pull-downs
  always_comb begin
    keypad_return = 4'h0;
    thumbwheel_in = 8'h00;
    for (int c = 0; c < 4; c++) begin
      if (keypad_drive[c]) begin
        keypad_return = keypad_return | key_map[c*4 +: 4];
      end
      if (thumbwheel_strobe[c]) begin
        thumbwheel_in = thumbwheel_in | {sw1[c*4 +: 4], sw0[c*4 +: 4]};
      end
    end
  end
endmodule

// >>> testbench.sv
// Self-checking bench for the key and switch scanner against a queue-based reference
`timescale 1ns/1ns
module testbench;
  import kds_pkg::*;
  localparam int SC = 8;
  logic        clk, reset_n, tk_en, mx_en, hex, wide, tw_en, mx_done, tw_done;
  logic [9:0]  tk_keys;
  logic [10:0] tk_st;
  logic [15:0] km, sw0, sw1, tk_res, w0, w1;
  logic [1:0]  tw_cnt;
  logic [3:0]  ret, drv, strb;
  logic [7:0]  tw_in, mx_st;
  logic [31:0] mx_res, seed;
  int          err_count, n_tests, k, e1, tq[$], mq[$];
  int          td[5] = '{5, 3, 0, 1, 2};

  kds_scanner #(.SCAN_CYCLES(SC)) dut (.clk(clk), .reset_n(reset_n), .ten_key_keys(tk_keys),
    .ten_key_enable(tk_en), .ten_key_result(tk_res), .ten_key_status(tk_st), .keypad_return(ret),
    .keypad_drive(drv), .matrix_enable(mx_en), .hex_mode_flag(hex), .matrix_keypad_entry_wide(wide),
    .keypad_result(mx_res), .keypad_status(mx_st), .keypad_done_flag(mx_done), .thumbwheel_in(tw_in),
    .thumbwheel_count(tw_cnt), .thumbwheel_enable(tw_en), .thumbwheel_strobe(strb),
    .thumbwheel_word0(w0), .thumbwheel_word1(w1), .thumbwheel_done_flag(tw_done));
  kds_keys_model keys (.keypad_drive(drv), .key_map(km), .thumbwheel_strobe(strb), .sw0(sw0),
    .sw1(sw1), .keypad_return(ret), .thumbwheel_in(tw_in));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Inputs always move 10 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reference: the last n digits folded in base b, oldest first
  function automatic logic [31:0] fold(input int q[$], input int n, input int b);
    logic [31:0] a;
    a = 32'h0;
    for (int i = (q.size() > n) ? q.size() - n : 0; i < q.size(); i++) begin
      a = 32'(a * b + q[i]);
    end
    return a;
  endfunction

  function automatic int dv(input logic [15:0] b);
    return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
  endfunction

  // Waits out n done pulses; a pulse must last one scan step exactly
  task automatic passes(input bit tw, input int n);
    int c;
    repeat (n) begin
      c = 0;
      while (!(tw ? tw_done : mx_done) && c < 100) begin
        tick(1);
        c++;
      end
      c = 0;
      while (tw ? tw_done : mx_done) begin
        tick(1);
        c++;
      end
      chk(32'(c), 32'(SC));
    end
  endtask

  task automatic tk_press(input int d);
    tk_keys = 10'(1 << d);
    tick(8);
    chk(32'(tk_st[10]), 32'(tk_en));
    tk_keys = 10'h000;
    tick(8);
  endtask

  // Held over two done pulses, then released over two, so the key is seen once
  task automatic mx_key(input logic [15:0] m);
    km = m;
    passes(1'b0, 2);
    chk(32'($countones(drv)), 32'h1);
    km = 16'h0000;
    passes(1'b0, 2);
  endtask

  task automatic rst();
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    mq.delete();
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    {reset_n, tk_en, mx_en, hex, wide, tw_en, tk_keys, km, sw0, sw1, tw_cnt} = '0;
    err_count = 0;
    n_tests = 0;
    seed = 32'h13ad8; // 80600
    tick(4);
    reset_n = 1'b1;
    tk_en = 1'b1;
    foreach (td[i]) begin
      tk_press(td[i]);
      tq.push_back(td[i]);
      chk(32'(tk_res), fold(tq, 4, 10));
      chk(32'(tk_st), 32'(1 << td[i]));
    end
    tk_en = 1'b0;
    tk_press(9);
    chk(32'(tk_res), fold(tq, 4, 10));
    chk(32'(tk_st), 32'h0);
    $display("test ten_key done");
    // Wide hex entry; once a larger key of the same drive column joins, and the smaller must win
    {mx_en, hex, wide} = 3'h7;
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      k = int'(seed[3:0]);
      mx_key(16'(1 << k) | ((i == 4) ? 16'(1 << (k | 3)) : 16'h0000));
      mq.push_back(k);
      chk(mx_res, fold(mq, 8, 16));
    end
    rst();
    {hex, wide} = 2'h0;
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      k = int'(seed[7:0] % 10);
      mx_key(16'(1 << k));
      mq.push_back(k);
      chk(mx_res, fold(mq, 4, 10));
    end
    km = 16'h0400;
    passes(1'b0, 2);
    chk(32'(mx_st), 32'h41);
    km = 16'h2400;
    passes(1'b0, 2);
    chk(32'(mx_st), 32'h41);
    mx_key(16'h0000);
    km = 16'h2000;
    passes(1'b0, 2);
    chk(32'(mx_st), 32'h48);
    km = 16'h0080;
    passes(1'b0, 2);
    mq.push_back(7);
    chk(32'(mx_st), 32'h88);
    mx_en = 1'b0;
    tick(3);
    chk(32'({mx_st, drv}), 32'h0);
    chk(mx_res, fold(mq, 4, 10));
    km = 16'h0000;
    $display("test matrix done");
    tw_en = 1'b1;
    for (int n = 2; n > 0; n--) begin
      tw_cnt = 2'(n);
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        {sw1, sw0} = {sw1, sw0} << 4 | 32'(seed[7:0] % 10);
      end
      e1 = (n == 2) ? dv(sw1) : e1;
      passes(1'b1, 2);
      chk(32'(w0), 32'(dv(sw0)));
      chk(32'(w1), 32'(e1));
    end
    tw_en = 1'b0;
    tick(3);
    chk(32'(strb), 32'h0);
    $display("test thumbwheel done");
    end_of_test();
  end
endmodule
